/* File: bench/sleep_wakeup_control_tb.sv */
// Purpose: Self-checking bench for the sleep and wake-up controller
// Assumes: Watchdog shortened to 64 cycles
// Notes:   Wake sources, flags and entry to programming checked at the ports
`timescale 1ns/100ps

module sleep_wakeup_control_tb;
  import slpwk_pkg::*;
  logic clk, reset, bus_we, bus_re, sleep_exec, watchdog_clear_instruction, global_irq_enable;
  logic master_clear_pin_n, programming_voltage_level, prog_clock_pin, prog_data_pin, pdat;
  logic osc_driver_en, in_sleep, fetch_next, wake_resume, irq_vector_req, device_reset;
  logic wdt_reset_req, power_down_flag, expiry_flag, prog_mode, prog_data_out, prog_data_oe;
  logic prog_mem_we;
  logic [13:0] bus_addr, vector_addr, prog_mem_addr, prog_mem_wdata, wseen;
  logic [7:0] bus_wdata, bus_rdata, port_out_core, port_oe_core, port_out, port_oe;
  logic [15:0] held;
  logic [IRQ_N-1:0] irq_flag, irq_enable;
  int fails, compares, cyc, seed, k, n;

  // ****************************************
  // Clock, design and programmer
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  assign prog_data_pin = prog_data_oe ? prog_data_out : pdat;
  slpwk_ctrl #(.WDT_CYCLES(64)) dut (
    .clk, .reset, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata, .sleep_exec,
    .watchdog_clear_instruction, .irq_flag, .irq_enable, .global_irq_enable,
    .master_clear_pin_n, .programming_voltage_level, .port_out_core, .port_oe_core,
    .port_out, .port_oe, .osc_driver_en, .in_sleep, .fetch_next, .wake_resume,
    .irq_vector_req, .vector_addr, .device_reset, .wdt_reset_req, .power_down_flag,
    .expiry_flag, .prog_mode, .prog_clock_pin, .prog_data_pin, .prog_data_out,
    .prog_data_oe, .prog_mem_addr, .prog_mem_rdata(14'h0000), .prog_mem_wdata, .prog_mem_we
  );
  slpwk_prog_model prog (.clk, .vpp(programming_voltage_level), .pclk(prog_clock_pin), .pdat);

  // Capture array writes and cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (prog_mem_we === 1'b1) wseen <= prog_mem_wdata;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] stat(input logic pd, input logic to);
    return {3'h0, to, pd, 3'h0};
  endfunction
  // Register bus cycles
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge clk);
    bus_we <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge clk);
    bus_re <= 1'b0;
    @(negedge clk);
    chk("bus_rdata", {8'h00, e}, {8'h00, bus_rdata});
  endtask
  // Clear the watchdog, then issue the sleep instruction
  task automatic do_sleep();
    @(posedge clk);
    watchdog_clear_instruction <= 1'b1;
    @(posedge clk);
    watchdog_clear_instruction <= 1'b0;
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_wake(input int lim);
    n = 0;
    while (!(wake_resume === 1'b1 || wdt_reset_req === 1'b1) && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Main sequence
  initial begin
    seed = 32'hC3B1;
    {reset, bus_we, bus_re, sleep_exec, watchdog_clear_instruction} = 5'h10;
    {global_irq_enable, master_clear_pin_n, bus_addr, bus_wdata} = 24'h400000;
    {irq_flag, irq_enable, port_out_core, port_oe_core} = '0;
    {fails, compares, cyc, wseen} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_STATUS, stat(1'b1, 1'b1));
    rd(ADDR_OPTION, OPTION_RESET);
    rd(ADDR_CONFIG, CONFIG_RESET);
    rd(14'h0055, 8'h00);
    chk("vector", IRQ_VECTOR, vector_addr);
    @(posedge clk);
    irq_flag <= 10'h001;
    irq_enable <= '1;
    do_sleep();
    chk("pending", 16'h0007, {in_sleep, power_down_flag, expiry_flag, fetch_next});
    @(posedge clk);
    {irq_flag, irq_enable} <= '0;
    wr(ADDR_OPTION, 8'h00);
    wait_wake(100);
    chk("run_expiry", 1'b1, wdt_reset_req);
    @(negedge clk);
    chk("to_flag", 1'b0, expiry_flag);
    do_sleep();
    wait_wake(100);
    chk("wdt_wake", 16'h0101, {7'h0, wake_resume, 6'h0, wdt_reset_req, n > 50});
    @(negedge clk);
    chk("to_flag", 1'b0, expiry_flag);
    wr(ADDR_CONFIG, 8'h7B);
    do_sleep();
    wait_wake(200);
    chk("wdt_off", 1'b1, in_sleep);
    for (k = 0; k < IRQ_N; k++) begin
      held = {port_oe, port_out};
      @(posedge clk);
      port_out_core <= 8'($random(seed));
      port_oe_core <= 8'($random(seed));
      global_irq_enable <= 1'($random(seed));
      irq_enable <= ~(10'h001 << k);
      irq_flag <= 10'h001 << k;
      repeat (3) @(negedge clk);
      chk("ports", held, {port_oe, port_out});
      chk("gated", 1'b1, in_sleep);
      @(posedge clk);
      irq_enable <= '1;
      @(posedge clk);
      @(negedge clk);
      chk("wake", k < 9, wake_resume);
      chk("vec_req", k < 9 && global_irq_enable, irq_vector_req);
      @(posedge clk);
      {irq_flag, irq_enable} <= 20'h00401;
      wait_wake(5);
      @(posedge clk);
      {irq_flag, irq_enable} <= '0;
      do_sleep();
      chk("sleep", 16'h0015, {in_sleep, power_down_flag, expiry_flag, osc_driver_en, fetch_next});
    end
    wr(ADDR_CONFIG, 8'h78);
    @(posedge clk);
    {irq_flag, irq_enable} <= 20'h00401;
    wait_wake(1100);
    chk("ost", 1'b1, n >= OST_TOSC && n <= OST_TOSC + 6);
    wr(ADDR_CONFIG, 8'h7B);
    @(posedge clk);
    {irq_flag, irq_enable} <= '0;
    do_sleep();
    @(posedge clk);
    master_clear_pin_n <= 1'b0;
    @(negedge clk);
    chk("reset_out", 1'b1, device_reset);
    @(posedge clk);
    master_clear_pin_n <= 1'b1;
    @(negedge clk);
    chk("master_clear_pin", 16'h0000, {in_sleep, wake_resume, power_down_flag});
    prog.enter();
    @(negedge clk);
    chk("prog_mode", {1'b1, PC_START}, {prog_mode, prog_mem_addr});
    prog.send({8'h00, CMD_LOAD}, 6);
    prog.send(14'h2A5C, 14);
    repeat (4) @(posedge clk);
    chk("load", 14'h2A5C, wseen);
    close_out();
  end
endmodule

/* File: bench/slpwk_prog_model.sv */
// Purpose: Serial programmer model for program/verify entry
// Assumes: Bits leave LSB first, one slow clock pulse per bit
// Notes:   Clock and data stay low while the high voltage rises
`timescale 1ns/100ps

module slpwk_prog_model (
  input  wire logic clk,
  output logic      vpp,
  output logic      pclk,
  output logic      pdat
);
  // ****************************************
  // Programmer pins
  // ****************************************
  initial begin
    vpp = 1'b0;
    pclk = 1'b0;
    pdat = 1'b0;
  end

  // Raise the high voltage with clock and data held low
  task automatic enter();
    @(posedge clk);
    pclk <= 1'b0;
    pdat <= 1'b0;
    repeat (2) @(posedge clk);
    vpp <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Shift n bits LSB first, data set up before each rise
  task automatic send(input logic [13:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      pdat <= v[i];
      @(posedge clk);
      pclk <= 1'b1;
      repeat (2) @(posedge clk);
      pclk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

/* File: hw/slpwk_ctrl.sv */
// Purpose: Power-down entry, wake-up, watchdog and serial program/verify entry
// Assumes: All inputs synchronous to clk; the sequencer supplies instruction pulses
// Notes:   Operation
// Operation
// - Watchdog clear zeroes prescaler, keeps assignment
// - Only sleep instruction enters power-down
// - Sleep clears watchdog and power-down flag, sets expiry flag, stops oscillator
// - Ports hold drive state while asleep
// - Wake on clear, watchdog, or interrupt
// - Master clear resets; others resume execution
// - Power-down flag set at power-up
// - Watchdog expiry clears expiry flag
// - Only listed peripherals may wake
// - Phase-clocked peripherals silent during sleep
// - Sleep prefetches following instruction
// - Individual enable gates wake, global ignored
// - After wake, vector only if global enabled
// - Pending interrupt makes sleep a no-op
// - Late interrupt: finish sleep, then wake
// - Crystal modes wait 1024 periods on wake
// - Readout allowed when code unprotected
// - ID words only in program/verify mode
// - Low clock/data at high voltage enters programming
// - Six-bit command then fourteen data bits
// - Expiry resets when running, wakes when asleep
// - Enable bit clear disables watchdog entirely
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps

module slpwk_ctrl
  import slpwk_pkg::*;
#(
  parameter int WDT_CYCLES = WDT_CYCLES_DOC
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [13:0]      bus_addr,
  input  wire logic [7:0]       bus_wdata,
  input  wire logic             bus_we,
  input  wire logic             bus_re,
  output logic      [7:0]       bus_rdata,
  input  wire logic             sleep_exec,
  input  wire logic             watchdog_clear_instruction,
  input  wire logic [IRQ_N-1:0] irq_flag,
  input  wire logic [IRQ_N-1:0] irq_enable,
  input  wire logic             global_irq_enable,
  input  wire logic             master_clear_pin_n,
  input  wire logic             programming_voltage_level,
  input  wire logic [7:0]       port_out_core,
  input  wire logic [7:0]       port_oe_core,
  output logic      [7:0]       port_out,
  output logic      [7:0]       port_oe,
  output logic                  osc_driver_en,
  output logic                  in_sleep,
  output logic                  fetch_next,
  output logic                  wake_resume,
  output logic                  irq_vector_req,
  output logic      [13:0]      vector_addr,
  output logic                  device_reset,
  output logic                  wdt_reset_req,
  output logic                  power_down_flag,
  output logic                  expiry_flag,
  output logic                  prog_mode,
  input  wire logic             prog_clock_pin,
  input  wire logic             prog_data_pin,
  output logic                  prog_data_out,
  output logic                  prog_data_oe,
  output logic      [13:0]      prog_mem_addr,
  input  wire logic [13:0]      prog_mem_rdata,
  output logic      [13:0]      prog_mem_wdata,
  output logic                  prog_mem_we
);

  // ****************************************
  // Declarations
  // ****************************************
  slpwk_state_t   state;
  slpwk_phase_t   phase;
  logic [7:0]     option_reg;
  logic [7:0]     config_reg;
  logic [WDT_W-1:0] wdt_cnt;
  logic [7:0]     pre_cnt;
  logic [7:0]     pre_limit;
  logic [OST_W-1:0] ost_cnt;
  logic [OST_W-1:0] ost_len;
  logic           wdt_enabled;
  logic           wdt_tick;
  logic           wdt_expire;
  logic           prescaler_assign;
  logic           pending;
  logic           wake_irq;
  logic           sleep_take;
  logic           rc_mode;
  logic           irq_woke;
  logic           master_clear_pin_active;
  logic           clk_prev;
  logic           vpp_prev;
  logic           pin_fall;
  logic           pin_rise;
  logic [5:0]     cmd_sh;
  logic [5:0]     next_cmd;
  logic [13:0]    dat_sh;
  logic [13:0]    next_dat;
  logic [13:0]    rd_sh;
  logic [13:0]    rd_value;
  logic [4:0]     bit_cnt;
  logic           prog_cfg_we;
  logic           prog_id_we;
  logic [13:0]    id_word [ID_N];
  logic           is_id;

  assign wdt_enabled = config_reg[CFG_WATCHDOG_ENABLE_CFG];
  assign prescaler_assign         = option_reg[OPT_PSA];
  assign rc_mode     = config_reg[CFG_OSC_HI:CFG_OSC_LO] == OSC_MODE_RC;
  assign master_clear_pin_active = !master_clear_pin_n && !prog_mode;
  assign pending     = |(irq_flag & irq_enable);
  assign wake_irq    = |(irq_flag & irq_enable & WAKE_MASK);
  assign sleep_take  = (state == ST_RUN) && sleep_exec && !pending;
  assign in_sleep    = state == ST_SLEEP;
  assign osc_driver_en = state != ST_SLEEP;
  assign vector_addr = IRQ_VECTOR;
  assign device_reset = master_clear_pin_active;

  // ****************************************
  // Register bus
  // ****************************************
  // Option and configuration writes; programmer may also write config
  always_ff @(posedge clk) begin
    if (reset) begin
      option_reg <= OPTION_RESET;
      config_reg <= CONFIG_RESET;
    end else begin
      if (bus_we && bus_addr == ADDR_OPTION) begin
        option_reg <= bus_wdata;
      end
      if (bus_we && bus_addr == ADDR_CONFIG) begin
        config_reg <= bus_wdata & CONFIG_MASK;
      end else if (prog_cfg_we) begin
        config_reg <= next_dat[7:0] & CONFIG_MASK;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (bus_re) begin
      case (bus_addr)
        ADDR_OPTION: bus_rdata <= option_reg;
        ADDR_CONFIG: bus_rdata <= config_reg;
        ADDR_STATUS: bus_rdata <= 8'((expiry_flag << STAT_TO) | (power_down_flag << STAT_PD));
        default:     bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Watchdog and prescaler
  // ****************************************
  assign pre_limit  = 8'((8'h01 << option_reg[OPT_PS_MSB:OPT_PS_LSB]) - 8'h01);
  assign wdt_tick   = wdt_enabled && (wdt_cnt == WDT_W'(WDT_CYCLES - 1));
  assign wdt_expire = wdt_tick && (!prescaler_assign || pre_cnt == pre_limit);

  // Base count and prescaler; clear instruction and sleep restart the count, and the prescaler only when it is assigned
  always_ff @(posedge clk) begin
    if (reset || master_clear_pin_active) begin
      wdt_cnt <= '0;
      pre_cnt <= 8'h00;
    end else if (watchdog_clear_instruction || sleep_take) begin
      wdt_cnt <= '0;
      if (prescaler_assign) begin
        pre_cnt <= 8'h00;
      end
    end else if (!wdt_enabled) begin
      wdt_cnt <= '0;
    end else if (wdt_tick) begin
      wdt_cnt <= '0;
      pre_cnt <= wdt_expire ? 8'h00 : 8'(pre_cnt + 8'h01);
    end else begin
      wdt_cnt <= WDT_W'(wdt_cnt + 1'b1);
    end
  end

  // ****************************************
  // Power state sequencing
  // ****************************************
  // Run, sleep and oscillator start-up wait
  always_ff @(posedge clk) begin
    if (reset || master_clear_pin_active) begin
      state    <= ST_RUN;
      ost_cnt  <= '0;
      irq_woke <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (sleep_take) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wdt_expire || wake_irq) begin
            irq_woke <= wake_irq && !wdt_expire;
            ost_cnt  <= '0;
            state    <= rc_mode ? ST_RUN : ST_OST;
          end
        end
        ST_OST: begin
          if (ost_cnt == OST_W'(OST_CYCLES - 1)) begin
            state <= ST_RUN;
          end else begin
            ost_cnt <= OST_W'(ost_cnt + 1'b1);
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Resume, vector, prefetch and watchdog reset pulses
  always_ff @(posedge clk) begin
    if (reset || master_clear_pin_active) begin
      wake_resume    <= 1'b0;
      irq_vector_req <= 1'b0;
      fetch_next     <= 1'b0;
      wdt_reset_req  <= 1'b0;
    end else begin
      wake_resume <= (state == ST_OST && ost_cnt == OST_W'(OST_CYCLES - 1)) ||
                     (state == ST_SLEEP && rc_mode && (wdt_expire || wake_irq));
      irq_vector_req <= global_irq_enable &&
                        ((state == ST_OST && ost_cnt == OST_W'(OST_CYCLES - 1) && irq_woke) ||
                         (state == ST_SLEEP && rc_mode && wake_irq && !wdt_expire));
      fetch_next    <= (state == ST_RUN) && sleep_exec;
      wdt_reset_req <= (state == ST_RUN) && wdt_expire;
    end
  end

  // Status flags; the watchdog expiry beats a sleep in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      power_down_flag <= 1'b1;
      expiry_flag     <= 1'b1;
    end else if (wdt_expire) begin
      expiry_flag <= 1'b0;
    end else if (sleep_take) begin
      power_down_flag <= 1'b0;
      expiry_flag     <= 1'b1;
    end
  end

  // Port drive frozen while asleep
  always_ff @(posedge clk) begin
    if (reset) begin
      port_out <= 8'h00;
      port_oe  <= 8'h00;
    end else if (state != ST_SLEEP) begin
      port_out <= port_out_core;
      port_oe  <= port_oe_core;
    end
  end

  // ****************************************
  // Serial program/verify
  // ****************************************
  assign pin_fall = clk_prev && !prog_clock_pin;
  assign pin_rise = !clk_prev && prog_clock_pin;
  assign next_cmd = {prog_data_pin, cmd_sh[5:1]};
  assign next_dat = {prog_data_pin, dat_sh[13:1]};
  assign is_id    = prog_mem_addr[13:2] == ID_BASE[13:2];
  assign prog_cfg_we = prog_mode && phase == PH_LOAD && pin_fall &&
                       bit_cnt == 5'(DATA_BITS - 1) && prog_mem_addr == ADDR_CONFIG;
  assign prog_id_we  = prog_mode && phase == PH_LOAD && pin_fall &&
                       bit_cnt == 5'(DATA_BITS - 1) && is_id;

  // Readout value; array gated by code protection
  always_comb begin
    if (prog_mem_addr < ID_BASE) begin
      rd_value = (config_reg[CFG_CP_HI] && config_reg[CFG_CP_LO]) ?
                 prog_mem_rdata : 14'h0000;
    end else if (is_id) begin
      rd_value = id_word[prog_mem_addr[1:0]];
    end else if (prog_mem_addr == ADDR_CONFIG) begin
      rd_value = {6'h00, config_reg};
    end else begin
      rd_value = 14'h0000;
    end
  end

  // Mode entry, command and data shifting
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_mode     <= 1'b0;
      phase         <= PH_CMD;
      clk_prev      <= 1'b0;
      vpp_prev      <= 1'b0;
      cmd_sh        <= 6'h00;
      dat_sh        <= 14'h0000;
      rd_sh         <= 14'h0000;
      bit_cnt       <= 5'h00;
      prog_data_out <= 1'b0;
      prog_data_oe  <= 1'b0;
      prog_mem_addr <= PC_START;
      prog_mem_wdata <= 14'h0000;
      prog_mem_we   <= 1'b0;
    end else begin
      clk_prev    <= prog_clock_pin;
      vpp_prev    <= programming_voltage_level;
      prog_mem_we <= 1'b0;
      if (!programming_voltage_level) begin
        prog_mode    <= 1'b0;
        prog_data_oe <= 1'b0;
      end else if (!vpp_prev && !prog_clock_pin && !prog_data_pin) begin
        prog_mode     <= 1'b1;
        phase         <= PH_CMD;
        bit_cnt       <= 5'h00;
        prog_mem_addr <= PC_START;
      end else if (prog_mode) begin
        case (phase)
          PH_CMD: begin
            if (pin_fall) begin
              cmd_sh  <= next_cmd;
              bit_cnt <= 5'(bit_cnt + 5'h01);
              if (bit_cnt == 5'(CMD_BITS - 1)) begin
                bit_cnt <= 5'h00;
                case (next_cmd)
                  CMD_LOAD: phase <= PH_LOAD;
                  CMD_READ: begin
                    phase        <= PH_READ;
                    rd_sh        <= rd_value;
                    prog_data_oe <= 1'b1;
                  end
                  CMD_INC:  prog_mem_addr <= 14'(prog_mem_addr + 14'h0001);
                  default:  phase <= PH_CMD;
                endcase
              end
            end
          end
          PH_LOAD: begin
            if (pin_fall) begin
              dat_sh  <= next_dat;
              bit_cnt <= 5'(bit_cnt + 5'h01);
              if (bit_cnt == 5'(DATA_BITS - 1)) begin
                bit_cnt        <= 5'h00;
                phase          <= PH_CMD;
                prog_mem_wdata <= next_dat;
                prog_mem_we    <= prog_mem_addr < ID_BASE;
              end
            end
          end
          PH_READ: begin
            if (pin_rise) begin
              prog_data_out <= rd_sh[0];
              rd_sh         <= {1'b0, rd_sh[13:1]};
              bit_cnt       <= 5'(bit_cnt + 5'h01);
            end else if (pin_fall && bit_cnt == 5'(DATA_BITS)) begin
              bit_cnt      <= 5'h00;
              prog_data_oe <= 1'b0;
              phase        <= PH_CMD;
            end
          end
          default: phase <= PH_CMD;
        endcase
      end
    end
  end

  // Identification words, reachable only from the programmer
  for (genvar i = 0; i < ID_N; i++) begin : g_id
    always_ff @(posedge clk) begin
      if (reset) begin
        id_word[i] <= 14'h0000;
      end else if (prog_id_we && prog_mem_addr[1:0] == 2'(i)) begin
        id_word[i] <= next_dat;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Helper count of start-up wait cycles, independent of the state counter
  always_ff @(posedge clk) begin
    if (reset || master_clear_pin_active || state != ST_OST) begin
      ost_len <= '0;
    end else begin
      ost_len <= OST_W'(ost_len + 1'b1);
    end
  end

  a_sleep_entry_only: assert property (@(posedge clk) disable iff (reset)
    $rose(in_sleep) |-> $past(sleep_exec))
    else $error("power-down entered without sleep instruction");

  a_sleep_sets_flags: assert property (@(posedge clk) disable iff (reset)
    sleep_take && !wdt_expire && !master_clear_pin_active |-> ##1 !power_down_flag && expiry_flag
      && wdt_cnt == '0 && !osc_driver_en)
    else $error("sleep did not clear watchdog or set flags");

  a_pending_nop: assert property (@(posedge clk) disable iff (reset)
    state == ST_RUN && sleep_exec && pending && !wdt_expire && !master_clear_pin_active
      |-> ##1 state == ST_RUN && power_down_flag == $past(power_down_flag))
    else $error("sleep with pending interrupt was not a no-op");

  a_ports_frozen: assert property (@(posedge clk) disable iff (reset)
    in_sleep && $past(in_sleep) |-> $stable(port_out) && $stable(port_oe))
    else $error("port drive changed during power-down");

  a_wdt_wakes: assert property (@(posedge clk) disable iff (reset)
    in_sleep && wdt_expire && !master_clear_pin_active |-> ##1 !in_sleep && !expiry_flag && !wdt_reset_req)
    else $error("watchdog expiry did not wake cleanly");

  a_wdt_resets_run: assert property (@(posedge clk) disable iff (reset)
    state == ST_RUN && wdt_expire && !master_clear_pin_active |-> ##1 wdt_reset_req && !expiry_flag)
    else $error("running watchdog expiry did not reset");

  a_wdt_disabled: assert property (@(posedge clk) disable iff (reset)
    !wdt_enabled |-> !wdt_expire && !wdt_reset_req)
    else $error("disabled watchdog expired");

  a_watchdog_clear_instruction_prescale: assert property (@(posedge clk) disable iff (reset)
    watchdog_clear_instruction && prescaler_assign && !bus_we |-> ##1 pre_cnt == 8'h00 && prescaler_assign)
    else $error("watchdog clear left prescaler count");

  a_masked_stays: assert property (@(posedge clk) disable iff (reset)
    in_sleep && !wake_irq && !wdt_expire && !master_clear_pin_active |-> ##1 in_sleep)
    else $error("woke without enabled wake source");

  a_ost_wait: assert property (@(posedge clk) disable iff (reset || master_clear_pin_active)
    wake_resume && $past(state == ST_OST) |-> $past(ost_len) == OST_W'(OST_CYCLES - 1))
    else $error("oscillator start-up wait has the wrong length");

  a_vector_gie: assert property (@(posedge clk) disable iff (reset)
    irq_vector_req |-> wake_resume && $past(global_irq_enable))
    else $error("vector requested without global enable");

  a_prog_entry: assert property (@(posedge clk) disable iff (reset)
    $rose(prog_mode) |-> $past(!prog_clock_pin && !prog_data_pin && programming_voltage_level)
      && prog_mem_addr == PC_START)
    else $error("program mode entered without low clock and data");

endmodule

/* File: include/slpwk_pkg.sv */
// Purpose: Shared constants and types for the sleep and wake-up controller
// Assumes: One 20 MHz clock that is also the oscillator period reference
// Notes:   All offsets, field positions and timing figures live here

package slpwk_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [13:0] ADDR_OPTION = 14'h0081;
  localparam logic [13:0] ADDR_CONFIG = 14'h2007;
  localparam logic [13:0] ADDR_STATUS = 14'h0003;

  // Option register fields
  localparam int OPT_PSA    = 3;
  localparam int OPT_PS_MSB = 2;
  localparam int OPT_PS_LSB = 0;
  localparam logic [7:0] OPTION_RESET = 8'hFF;

  // Configuration word fields
  localparam int CFG_CP_HI = 5;
  localparam int CFG_CP_LO = 4;
  localparam int CFG_WATCHDOG_ENABLE_CFG  = 2;
  localparam int CFG_OSC_HI = 1;
  localparam int CFG_OSC_LO = 0;
  localparam logic [7:0] CONFIG_MASK  = 8'h7F;
  localparam logic [7:0] CONFIG_RESET = 8'h7F;
  localparam logic [1:0] OSC_MODE_RC  = 2'h3;

  // Status bits
  localparam int STAT_PD = 3;
  localparam int STAT_TO = 4;

  // ****************************************
  // Interrupt sources
  // ****************************************
  localparam int IRQ_N = 10;
  // 0 ext pin, 1 port change, 2 timer1 async, 3 serial start/stop, 4 serial slave,
  // 5 capture, 6 parallel slave, 7 conversion on RC clock, 8 sync-slave usart, 9 timer0
  localparam logic [IRQ_N-1:0] WAKE_MASK = 10'h1FF;
  localparam logic [13:0] IRQ_VECTOR = 14'h0004;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 20_000_000;
  localparam int OSC_HZ     = 20_000_000;
  localparam int OST_TOSC   = 1024;
  localparam int OST_CYCLES = OST_TOSC * (CLK_HZ / OSC_HZ);
  localparam int WDT_MS     = 18;
  localparam int WDT_CYCLES_DOC = WDT_MS * (CLK_HZ / 1000);
  localparam int WDT_W      = 19;
  localparam int OST_W      = 11;

  // ****************************************
  // Serial program/verify
  // ****************************************
  localparam int CMD_BITS  = 6;
  localparam int DATA_BITS = 14;
  localparam logic [5:0] CMD_LOAD = 6'h02;
  localparam logic [5:0] CMD_READ = 6'h04;
  localparam logic [5:0] CMD_INC  = 6'h06;
  localparam logic [13:0] ID_BASE  = 14'h2000;
  localparam logic [13:0] PC_START = 14'h0000;
  localparam int ID_N = 4;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST} slpwk_state_t;
  typedef enum logic [1:0] {PH_CMD, PH_LOAD, PH_READ} slpwk_phase_t;

endpackage
